// >>> rtl/supervisor_status_control_regs.sv
// Status, fault latch, enable and key registers of a rail supervisor.
// Assumes a host on a serial link whose clock is sampled by i_clk, and
// analog comparators and watchdog logic outside this block.
//
// Overview of operation
// RULE_01 - Power enable bit: pin equals demanded level.
// RULE_02 - Reset match bit: pin equals demanded level.
// RULE_03 - Mirror logic and battery enable pin levels.
// RULE_04 - LDO good when regulated or switched off.
// RULE_05 - Boost drive good mirrors commanded-value match.
// RULE_06 - Catch diode good clears when diode missing.
// RULE_07 - Gate stuck-low flags in D19 to D16.
// RULE_08 - Gate stuck-high flags in D11 to D8.
// RULE_09 - Bridge supply low bit follows comparator.
// RULE_10 - Two-bit reset input select, default 00.
// RULE_11 - Watchdog state code, reserved codes never shown.
// RULE_12 - Error count bounded by 160 or 220.
// RULE_13 - Core rail faults sticky, write one clears.
// RULE_14 - Remote rail faults sticky, write one clears.
// RULE_15 - Gate pairs: 00 off, 11 on, else hold.
// RULE_16 - LDO pairs same coding, default on.
// RULE_17 - Watchdog keys D3, 33; wrong byte restarts.
// RULE_18 - Third byte CC to CF picks transition.
// RULE_19 - Reset keys D4, 2B; wrong byte restarts.
// RULE_20 - A5/A6/A7 add sources; fault holds 2 ms.
// RULE_21 - Master reset restores default reset selection.
// RULE_22 - Five-bit address decode; status read-only.
// RULE_23 - Dither disable bit, default zero.
// RULE_24 - Disabled LDO faults are masked entirely.
// RULE_25 - Unused bits read zero, writes ignored.
// RULE_26 - Status writes ignored; key reads return zero.
module supervisor_status_control_regs
	import supervisor_regs_pkg::*;
#(
	// Cycles the reset demand stays low after a watchdog fault.
	parameter int WD_HOLD_CYCLES = WD_FAULT_HOLD_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	output logic o_miso,
	input wire logic i_logic_enable_pin,
	input wire logic i_battery_enable_pin,
	input wire logic i_power_enable_output,
	input wire logic i_power_enable_demand,
	input wire logic i_reset_output,
	input wire logic i_mcu_rail_ok,
	input wire logic i_aux_rail_ok,
	input wire logic [1:0] i_remote_ldo_in_regulation,
	input wire logic i_boost_drive_match,
	input wire logic i_catch_diode_present,
	input wire logic i_bridge_supply_low,
	input wire logic [3:0] i_gate_source_high,
	input wire logic [6:0] i_core_rail_event,
	input wire logic [5:0] i_remote_rail_event,
	input wire logic [2:0] i_watchdog_state_code,
	input wire logic [7:0] i_pulse_watchdog_error_count,
	input wire logic i_pwwd_max_alt,
	input wire logic i_watchdog_fault,
	output logic [3:0] o_gate_enable,
	output logic [1:0] o_remote_ldo_enable,
	output logic o_dither_disable,
	output logic [1:0] o_reset_input_select,
	output logic o_reset_demand,
	output logic o_fault_n,
	output logic o_watchdog_cmd_valid,
	output logic [1:0] o_watchdog_cmd
);

	// All state of the block, registered by one process.
	typedef struct packed {
		logic [SYNC_W-1:0] sync1; // First stage, read only by sync2.
		logic [SYNC_W-1:0] sync2; // Settled copies of the pins.
		logic sck_d; // Last settled link clock, for edges.
		logic cs_d; // Last settled select, for edges.
		logic [5:0] bit_cnt; // Rising link clock edges seen in this frame.
		logic [31:0] rx; // Incoming frame.
		logic [31:0] tx; // Answer shifted out in the next frame.
		logic [3:0] gate_en; // Gate driver states, [0] is phase W.
		logic [1:0] ldo_en; // Remote LDO states, [0] is LDO 1.
		logic dither; // Dither disable.
		logic [1:0] rst_sel; // Reset input selection.
		key_state_e watchdog_mode_key; // Watchdog key progress.
		key_state_e rst_key; // Reset key progress.
		logic [6:0] core_latch; // Sticky core rail faults.
		logic [5:0] remote_latch; // Sticky remote rail faults.
		logic [2:0] wd_state; // Last legal watchdog state code.
		logic wd_cmd_valid; // One-cycle command strobe.
		wd_cmd_e wd_cmd; // Command that goes with the strobe.
		logic wdf_d; // Last watchdog fault level.
		logic [17:0] hold_cnt; // Remaining reset hold cycles.
		logic rst_dem; // Reset release demand.
		logic fault_n; // Fault output, low while a latch is set.
	} state_s;

	state_s s; // Current state.
	state_s n; // Next state.
	logic [SYNC_W-1:0] async_in; // Pins gathered for synchronising.
	logic sck_rise; // Settled link clock rose.
	logic sck_fall; // Settled link clock fell.
	logic cs_fall; // Frame started.
	logic frame_done; // Whole frame of 32 rising edges ended.
	logic wr; // Finished frame is a write.
	logic [4:0] addr; // Address of the finished frame.
	logic [15:0] wdata; // Data of the finished frame.
	logic [15:0] rdata; // Read value of the addressed register.
	logic [15:0] pin_word; // Pin check status word.
	logic [15:0] rail_word; // Rail status word.
	logic [15:0] gate_word; // Gate and watchdog status word.
	logic [15:0] count_word; // Error counter word.
	logic [15:0] core_word; // Core latch word.
	logic [15:0] remote_word; // Remote latch word.
	logic [15:0] enable_word; // Enable pairs word.
	logic [3:0] stuck_low; // Gate commanded on but low.
	logic [3:0] stuck_high; // Gate commanded off but high.
	logic [7:0] count_max; // Selected counter ceiling.
	logic [7:0] count_shown; // Counter clamped to its ceiling.
	logic [5:0] remote_ev; // Remote events after masking.
	logic [6:0] core_clr; // Write-one-to-clear mask, core.
	logic [5:0] remote_clr; // Write-one-to-clear mask, remote.
	logic [7:0] wd_byte; // Watchdog key byte of a key write.
	logic [7:0] rst_byte; // Reset key byte of a key write.
	logic key_wr; // Key register written.

	// Gather the pins so one vector passes two flip-flops.
	assign async_in = {i_remote_rail_event, i_core_rail_event,
		i_gate_source_high, i_bridge_supply_low, i_catch_diode_present,
		i_boost_drive_match, i_remote_ldo_in_regulation, i_aux_rail_ok,
		i_mcu_rail_ok, i_reset_output, i_power_enable_output,
		i_battery_enable_pin, i_logic_enable_pin, i_mosi, i_cs_n, i_sck};

	// Edges come from the second stage against a third copy, so the first
	// stage never feeds a decision while it may still be settling.
	assign sck_rise = s.sync2[SY_SCK] & ~s.sck_d;
	assign sck_fall = ~s.sync2[SY_SCK] & s.sck_d;
	assign cs_fall = ~s.sync2[SY_CS] & s.cs_d;
	// A frame with too few or too many edges is dropped whole.
	assign frame_done = s.sync2[SY_CS] & ~s.cs_d & (s.bit_cnt == FRAME_LEN);
	assign wr = s.rx[WRITE_BIT];
	assign addr = s.rx[ADDR_MSB:ADDR_LSB];
	assign wdata = s.rx[DATA_MSB:DATA_LSB];

	// Gate supervision is live: a flag shows while the mismatch lasts.
	assign stuck_low = s.gate_en & ~s.sync2[SY_GS +: 4]; // RULE_07
	assign stuck_high = ~s.gate_en & s.sync2[SY_GS +: 4]; // RULE_08

	// The counter belongs to the watchdog; here it is only bounded.
	assign count_max = i_pwwd_max_alt ? PWWD_MAX_ALT : PWWD_MAX_DEFAULT;
	assign count_shown = (i_pulse_watchdog_error_count > count_max) ?
		count_max : i_pulse_watchdog_error_count; // RULE_12

	// A switched-off LDO sags by design, so its faults never latch.
	assign remote_ev = s.sync2[SY_REMOTE +: 6] &
		{2'b11, {2{s.ldo_en[0]}}, {2{s.ldo_en[1]}}}; // RULE_24

	// Build the read words; all bits not placed read as zero.
	always_comb begin
		pin_word = 16'h0000; // RULE_25
		pin_word[POS_PE_MATCH] = (s.sync2[SY_PE_PIN] ==
			i_power_enable_demand); // RULE_01
		pin_word[POS_RST_MATCH] = (s.sync2[SY_RST_PIN] ==
			s.rst_dem); // RULE_02
		pin_word[POS_LOGIC_EN] = s.sync2[SY_LOGIC]; // RULE_03
		pin_word[POS_BAT_EN] = s.sync2[SY_BAT]; // RULE_03
		rail_word = 16'h0000;
		rail_word[POS_MCU_OK] = s.sync2[SY_MCU_OK];
		rail_word[POS_AUX_OK] = s.sync2[SY_AUX_OK];
		rail_word[POS_LDO_GOOD_HI] = ~s.ldo_en[0] |
			s.sync2[SY_LDO_REG]; // RULE_04
		rail_word[POS_LDO_GOOD_HI-1] = ~s.ldo_en[1] |
			s.sync2[SY_LDO_REG+1]; // RULE_04
		rail_word[POS_BOOST_GOOD] = s.sync2[SY_BOOST]; // RULE_05
		rail_word[POS_DIODE_GOOD] = s.sync2[SY_DIODE]; // RULE_06
		gate_word = 16'h0000;
		gate_word[POS_BRIDGE_LOW] = s.sync2[SY_BRIDGE]; // RULE_09
		gate_word[POS_STUCK_LOW_LSB +: 4] = stuck_low; // RULE_07
		gate_word[POS_RST_SEL_LSB +: 2] = s.rst_sel; // RULE_10
		gate_word[POS_STUCK_HIGH_LSB +: 4] = stuck_high; // RULE_08
		gate_word[POS_WD_STATE_LSB +: 3] = s.wd_state; // RULE_11
		count_word = {count_shown, 8'h00}; // RULE_12
		core_word = {4'h0, s.core_latch[6:3], 1'b0, s.core_latch[2:0],
			4'h0};
		remote_word = {s.remote_latch[5:4], 2'b00, s.remote_latch[3:0],
			8'h00};
		// Pairs read back as the state they produced, 00 or 11.
		enable_word = 16'h0000;
		for (int g = 0; g < 4; g++) begin
			enable_word[POS_GATE_EN1_HI-g] = s.gate_en[g];
			enable_word[POS_GATE_EN0_HI-g] = s.gate_en[g];
		end
		for (int l = 0; l < 2; l++) begin
			enable_word[POS_LDO_EN1_LSB+l] = s.ldo_en[l];
			enable_word[POS_LDO_EN0_LSB+l] = s.ldo_en[l];
		end
	end

	// Address decode; the key register and unknown codes read zero.
	always_comb begin
		unique case (addr) // RULE_22
		ADDR_PIN_CHECK: rdata = pin_word;
		ADDR_RAIL: rdata = rail_word;
		ADDR_GATE_WD: rdata = gate_word;
		ADDR_PWWD_COUNT: rdata = count_word;
		ADDR_CORE_LATCH: rdata = core_word;
		ADDR_REMOTE_LATCH: rdata = remote_word;
		ADDR_ENABLE: rdata = enable_word;
		ADDR_CONFIG: rdata = {s.dither, 15'h0000};
		default: rdata = 16'h0000; // RULE_26
		endcase
	end

	// Clear masks and key bytes exist only on a finished write frame.
	always_comb begin
		core_clr = 7'h00;
		remote_clr = 6'h00;
		key_wr = frame_done & wr & (addr == ADDR_KEY);
		if (frame_done & wr & (addr == ADDR_CORE_LATCH)) begin
			core_clr = {wdata[11:8], wdata[6:4]}; // RULE_13
		end
		if (frame_done & wr & (addr == ADDR_REMOTE_LATCH)) begin
			remote_clr = {wdata[15:14], wdata[11:8]}; // RULE_14
		end
		// A zero byte means the host left that key untouched.
		wd_byte = key_wr ? wdata[15:8] : 8'h00;
		rst_byte = key_wr ? wdata[7:0] : 8'h00;
	end

	// Next-state logic of the whole block.
	always_comb begin
		n = s;
		n.sync1 = async_in;
		n.sync2 = s.sync1;
		n.sck_d = s.sync2[SY_SCK];
		n.cs_d = s.sync2[SY_CS];
		n.wd_cmd_valid = 1'b0;
		n.wdf_d = i_watchdog_fault;
		// Link shifting: sample on rising, present on falling edges.
		if (cs_fall) begin
			n.bit_cnt = 6'h00;
		end else if (~s.sync2[SY_CS] & sck_rise) begin
			n.rx = {s.rx[30:0], s.sync2[SY_MOSI]};
			if (s.bit_cnt != 6'h3f) begin
				n.bit_cnt = s.bit_cnt + 6'h01;
			end
		end else if (~s.sync2[SY_CS] & sck_fall) begin
			n.tx = {s.tx[30:0], 1'b0};
		end
		// The answer shows the register as it stood before this write.
		if (frame_done) begin
			n.tx = {addr, 1'b0, 5'h00, rdata, 5'h00};
		end
		// Writes land only on writable registers.
		if (frame_done & wr) begin
			unique case (addr) // RULE_22
			ADDR_ENABLE: begin
				for (int g = 0; g < 4; g++) begin
					if (wdata[POS_GATE_EN1_HI-g] ==
						wdata[POS_GATE_EN0_HI-g]) begin
						n.gate_en[g] = wdata[POS_GATE_EN1_HI-g]; // RULE_15
					end
				end
				for (int l = 0; l < 2; l++) begin
					if (wdata[POS_LDO_EN1_LSB+l] ==
						wdata[POS_LDO_EN0_LSB+l]) begin
						n.ldo_en[l] = wdata[POS_LDO_EN1_LSB+l]; // RULE_16
					end
				end
			end
			ADDR_CONFIG: n.dither = wdata[POS_DITHER]; // RULE_23
			default: begin
				// Status registers and unused bits ignore writes.
				n.dither = s.dither; // RULE_26
			end
			endcase
		end
		// Sticky faults: a new event wins over a clear in the same cycle.
		n.core_latch = (s.core_latch & ~core_clr) |
			s.sync2[SY_CORE +: 7]; // RULE_13
		n.remote_latch = (s.remote_latch & ~remote_clr) |
			remote_ev; // RULE_14
		n.fault_n = ~(|n.core_latch | |n.remote_latch);
		// Watchdog key: any wrong byte sends progress back to the start.
		if (wd_byte != 8'h00) begin
			unique case (s.watchdog_mode_key)
			KEY_WAIT1: n.watchdog_mode_key = (wd_byte == WD_KEY1) ?
				KEY_WAIT2 : KEY_WAIT1; // RULE_17
			KEY_WAIT2: n.watchdog_mode_key = (wd_byte == WD_KEY2) ?
				KEY_WAIT3 : KEY_WAIT1; // RULE_17
			KEY_WAIT3: begin
				n.watchdog_mode_key = KEY_WAIT1;
				if (wd_byte >= WD_CMD_FLASH &&
					wd_byte <= WD_CMD_DISABLE) begin
					n.wd_cmd_valid = 1'b1; // RULE_18
					n.wd_cmd = wd_cmd_e'(wd_byte[1:0]);
				end
			end
			default: n.watchdog_mode_key = KEY_WAIT1;
			endcase
		end
		// Reset selection key, same pattern with its own bytes.
		if (rst_byte != 8'h00) begin
			unique case (s.rst_key)
			KEY_WAIT1: n.rst_key = (rst_byte == RST_KEY1) ?
				KEY_WAIT2 : KEY_WAIT1; // RULE_19
			KEY_WAIT2: n.rst_key = (rst_byte == RST_KEY2) ?
				KEY_WAIT3 : KEY_WAIT1; // RULE_19
			KEY_WAIT3: begin
				n.rst_key = KEY_WAIT1;
				if (rst_byte >= RST_ADD_WDF &&
					rst_byte <= RST_ADD_BOTH) begin
					// A5 gives 10, A6 gives 01, A7 gives 11.
					n.rst_sel = {rst_byte[0], rst_byte[1]}; // RULE_20
				end
			end
			default: n.rst_key = KEY_WAIT1;
			endcase
		end
		// Reserved codes keep the last legal state on show.
		if (i_watchdog_state_code <= WD_STATE_LAST) begin
			n.wd_state = i_watchdog_state_code; // RULE_11
		end
		// A new watchdog fault starts the hold when it is selected.
		if (i_watchdog_fault & ~s.wdf_d & s.rst_sel[1]) begin
			n.hold_cnt = WD_HOLD_CYCLES[17:0]; // RULE_20
		end else if (s.hold_cnt != 18'h00000) begin
			n.hold_cnt = s.hold_cnt - 18'h00001;
		end
		n.rst_dem = s.sync2[SY_MCU_OK] &
			(~s.rst_sel[0] | s.sync2[SY_AUX_OK]) &
			~(s.rst_sel[1] & (s.hold_cnt != 18'h00000)); // RULE_10
		// Master reset returns every control to its default.
		if (!i_rstn) begin
			n = '0;
			n.watchdog_mode_key = KEY_WAIT1;
			n.rst_key = KEY_WAIT1;
			n.gate_en = GATE_EN_RESET;
			n.ldo_en = LDO_EN_RESET;
			n.dither = DITHER_RESET;
			n.rst_sel = RST_SEL_RESET; // RULE_21
			n.wd_state = WD_STATE_IDLE;
			n.fault_n = 1'b1;
			n.sync1[SY_CS] = 1'b1;
			n.sync2[SY_CS] = 1'b1;
			n.cs_d = 1'b1;
		end
	end

	// The one register of the block.
	always_ff @(posedge i_clk) begin
		s <= n;
	end

	assign o_miso = s.tx[31];
	assign o_gate_enable = s.gate_en;
	assign o_remote_ldo_enable = s.ldo_en;
	assign o_dither_disable = s.dither;
	assign o_reset_input_select = s.rst_sel;
	assign o_reset_demand = s.rst_dem;
	assign o_fault_n = s.fault_n;
	assign o_watchdog_cmd_valid = s.wd_cmd_valid;
	assign o_watchdog_cmd = s.wd_cmd;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	gate_pair_on_a: assert property (frame_done && wr && // RULE_15
		addr == ADDR_ENABLE && wdata[15] && wdata[11]
		|=> o_gate_enable[0])
		else $error("gate pair 11 did not turn the driver on");
	gate_pair_hold_a: assert property (frame_done && wr && // RULE_15
		addr == ADDR_ENABLE && (wdata[15] != wdata[11])
		|=> $stable(o_gate_enable[0]))
		else $error("mismatched gate pair changed the driver");
	ldo_fault_mask_a: assert property (!s.ldo_en[0] && // RULE_24
		!s.remote_latch[3] |=> !s.remote_latch[3])
		else $error("disabled LDO fault was latched");
	core_sticky_a: assert property (s.core_latch[6] && // RULE_13
		!core_clr[6] |=> s.core_latch[6])
		else $error("core fault latch dropped without a clear");
	core_set_a: assert property (s.sync2[SY_CORE] // RULE_13
		|=> s.core_latch[0] && !o_fault_n)
		else $error("core event did not latch or raise fault");
	wd_state_legal_a: assert property (gate_word[2:0] <= // RULE_11
		WD_STATE_LAST)
		else $error("reserved watchdog state reported");
	count_bound_a: assert property (count_word[15:8] <= // RULE_12
		count_max)
		else $error("error count above its ceiling");
	reset_default_a: assert property (!$past(i_rstn) |-> // RULE_21
		o_reset_input_select == RST_SEL_RESET && o_gate_enable == 4'h0)
		else $error("controls not at default after reset");
	fault_hold_a: assert property (s.hold_cnt != 18'h00000 && // RULE_20
		s.rst_sel[1] |=> !o_reset_demand)
		else $error("reset released during watchdog hold");
	key_cmd_a: assert property (o_watchdog_cmd_valid |-> // RULE_18
		$past(s.watchdog_mode_key) == KEY_WAIT3 && $past(key_wr))
		else $error("watchdog command without full key");

endmodule : supervisor_status_control_regs

// >>> rtl/supervisor_regs_pkg.sv
// Constants for the supervisor status and control register bank.
// Assumes a 100 MHz core clock and a 32-bit serial frame per access.
package supervisor_regs_pkg;
	// Serial frame layout: address, write flag, 16 data bits (D20..D5).
	localparam logic [5:0] FRAME_LEN = 6'h20;
	localparam int ADDR_MSB = 31;
	localparam int ADDR_LSB = 27;
	localparam int WRITE_BIT = 26;
	localparam int DATA_MSB = 20;
	localparam int DATA_LSB = 5;
	// Five-bit register address codes.
	localparam logic [4:0] ADDR_PIN_CHECK = 5'h00;
	localparam logic [4:0] ADDR_RAIL = 5'h01;
	localparam logic [4:0] ADDR_GATE_WD = 5'h02;
	localparam logic [4:0] ADDR_PWWD_COUNT = 5'h03;
	localparam logic [4:0] ADDR_CORE_LATCH = 5'h04;
	localparam logic [4:0] ADDR_REMOTE_LATCH = 5'h05;
	localparam logic [4:0] ADDR_ENABLE = 5'h06;
	localparam logic [4:0] ADDR_KEY = 5'h07;
	localparam logic [4:0] ADDR_CONFIG = 5'h08;
	// Field positions inside the 16-bit word (word bit = D number - 5).
	localparam int POS_PE_MATCH = 4;
	localparam int POS_RST_MATCH = 3;
	localparam int POS_LOGIC_EN = 1;
	localparam int POS_BAT_EN = 0;
	localparam int POS_MCU_OK = 14;
	localparam int POS_AUX_OK = 13;
	localparam int POS_LDO_GOOD_HI = 10;
	localparam int POS_BOOST_GOOD = 5;
	localparam int POS_DIODE_GOOD = 4;
	localparam int POS_BRIDGE_LOW = 15;
	localparam int POS_STUCK_LOW_LSB = 11;
	localparam int POS_RST_SEL_LSB = 9;
	localparam int POS_STUCK_HIGH_LSB = 3;
	localparam int POS_WD_STATE_LSB = 0;
	localparam int POS_COUNT_LSB = 8;
	localparam int POS_GATE_EN1_HI = 15;
	localparam int POS_GATE_EN0_HI = 11;
	localparam int POS_LDO_EN1_LSB = 6;
	localparam int POS_LDO_EN0_LSB = 2;
	localparam int POS_DITHER = 15;
	// Positions of the asynchronous inputs in the synchroniser vector.
	localparam int SYNC_W = 31;
	localparam int SY_SCK = 0;
	localparam int SY_CS = 1;
	localparam int SY_MOSI = 2;
	localparam int SY_LOGIC = 3;
	localparam int SY_BAT = 4;
	localparam int SY_PE_PIN = 5;
	localparam int SY_RST_PIN = 6;
	localparam int SY_MCU_OK = 7;
	localparam int SY_AUX_OK = 8;
	localparam int SY_LDO_REG = 9;
	localparam int SY_BOOST = 11;
	localparam int SY_DIODE = 12;
	localparam int SY_BRIDGE = 13;
	localparam int SY_GS = 14;
	localparam int SY_CORE = 18;
	localparam int SY_REMOTE = 25;
	// Key bytes and commands.
	localparam logic [7:0] WD_KEY1 = 8'hd3;
	localparam logic [7:0] WD_KEY2 = 8'h33;
	localparam logic [7:0] WD_CMD_FLASH = 8'hcc;
	localparam logic [7:0] WD_CMD_DISABLE = 8'hcf;
	localparam logic [7:0] RST_KEY1 = 8'hd4;
	localparam logic [7:0] RST_KEY2 = 8'h2b;
	localparam logic [7:0] RST_ADD_WDF = 8'ha5;
	localparam logic [7:0] RST_ADD_BOTH = 8'ha7;
	// Watchdog state codes and counter limits.
	localparam logic [2:0] WD_STATE_IDLE = 3'h0;
	localparam logic [2:0] WD_STATE_LAST = 3'h5;
	localparam logic [7:0] PWWD_MAX_DEFAULT = 8'ha0;
	localparam logic [7:0] PWWD_MAX_ALT = 8'hdc;
	// Reset values.
	localparam logic [3:0] GATE_EN_RESET = 4'h0;
	localparam logic [1:0] LDO_EN_RESET = 2'h3;
	localparam logic [1:0] RST_SEL_RESET = 2'h0;
	localparam logic DITHER_RESET = 1'b0;
	// Reset hold after a watchdog fault.
	localparam int CLK_MHZ = 100;
	localparam int WD_FAULT_HOLD_US = 2000;
	localparam int WD_FAULT_HOLD_CYCLES = WD_FAULT_HOLD_US * CLK_MHZ;
	// Key sequence states, one-hot.
	typedef enum logic [2:0] {
		KEY_WAIT1 = 3'b001,
		KEY_WAIT2 = 3'b010,
		KEY_WAIT3 = 3'b100
	} key_state_e;
	// Watchdog transition commands, low bits of the third key byte.
	typedef enum logic [1:0] {
		WDC_FLASH = 2'h0,
		WDC_CONFIG = 2'h1,
		WDC_RESTART = 2'h2,
		WDC_DISABLE = 2'h3
	} wd_cmd_e;
endpackage : supervisor_regs_pkg

// >>> bench/host_link_model.sv
// Host side of the serial link: sends 32-bit frames MSB first.
// Assumes the device samples the link clock with its own clock.
module host_link_model (
	input wire logic i_clk,
	input wire logic i_miso,
	output logic o_sck,
	output logic o_cs_n,
	output logic o_mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	// The link clock stands low outside frames.
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end
	// Half a link period is eight core cycles, so 160 ns a bit.
	task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
		o_cs_n <= 1'b0;
		repeat (8) @(posedge i_clk);
		for (int i = 31; i >= 0; i--) begin
			o_mosi <= tx[i];
			repeat (8) @(posedge i_clk);
			o_sck <= 1'b1;
			rx[i] = i_miso;
			repeat (8) @(posedge i_clk);
			o_sck <= 1'b0;
		end
		repeat (8) @(posedge i_clk);
		// A released data line flips so a stale bit never looks valid.
		o_mosi <= ~o_mosi;
		o_cs_n <= 1'b1;
		repeat (12) @(posedge i_clk);
	endtask : frame
endmodule : host_link_model

// >>> bench/supervisor_status_control_regs_tb.sv
// Self-checking bench for the supervisor register bank.
// Assumes the host model file is compiled first.
module supervisor_status_control_regs_tb import supervisor_regs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0, i_rstn = 1'b0, i_sck, i_cs_n, i_mosi, o_miso;
	logic i_logic_enable_pin = 1'b0, i_battery_enable_pin = 1'b0;
	logic i_power_enable_output = 1'b0, i_power_enable_demand = 1'b0;
	logic i_mcu_rail_ok = 1'b0, i_aux_rail_ok = 1'b0, i_pwwd_max_alt = 1'b0;
	logic i_boost_drive_match = 1'b0, i_catch_diode_present = 1'b1;
	logic i_bridge_supply_low = 1'b0, i_watchdog_fault = 1'b0;
	logic [1:0] i_remote_ldo_in_regulation = 2'h3;
	logic [3:0] i_gate_source_high = 4'h0;
	logic [6:0] i_core_rail_event = 7'h0;
	logic [5:0] i_remote_rail_event = 6'h0;
	logic [2:0] i_watchdog_state_code = 3'h0;
	logic [7:0] i_pulse_watchdog_error_count = 8'h0;
	logic [3:0] o_gate_enable;
	logic [1:0] o_remote_ldo_enable, o_reset_input_select, o_watchdog_cmd;
	logic o_dither_disable, o_reset_demand, o_fault_n, o_watchdog_cmd_valid;
	logic i_reset_output;
	logic [1:0] last_cmd;
	int n_mismatch = 0, checked = 0, n_cmd = 0, cyc = 0;
	logic rst_pin_ok = 1'b0; // Reset pin follows its demand when set.
	// The reset pin starts stuck opposite, so its match flag must drop.
	assign i_reset_output = rst_pin_ok ? o_reset_demand : ~o_reset_demand;
	always #5 i_clk = ~i_clk;
	supervisor_status_control_regs #(.WD_HOLD_CYCLES(50)) DUT (.*);
	host_link_model HOST (.i_clk, .i_miso(o_miso), .o_sck(i_sck),
		.o_cs_n(i_cs_n), .o_mosi(i_mosi));
	// Records every one-cycle watchdog command pulse.
	always @(posedge i_clk) begin
		cyc++;
		if (o_watchdog_cmd_valid === 1'b1) begin
			n_cmd++;
			last_cmd = o_watchdog_cmd;
		end
		if (cyc == 70000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("compares %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [31:0] rx;
		HOST.frame({a, 6'h20, d, 5'h0}, rx);
	endtask : wr
	// The answer arrives in the next frame, a read of an unmapped address.
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		logic [31:0] rx;
		HOST.frame({a, 27'h0}, rx);
		HOST.frame({5'h1f, 27'h0}, rx);
		check(rx[20:5], e);
	endtask : rd
	task automatic key(input logic [7:0] w, input logic [7:0] r);
		wr(ADDR_KEY, {w, r});
	endtask : key
	task automatic t_reset();
		check(16'({o_gate_enable, o_remote_ldo_enable, o_dither_disable,
			o_reset_input_select, o_fault_n}), 16'h0031);
		rd(ADDR_ENABLE, 16'h00cc);
		rd(ADDR_KEY, 16'h0);
	endtask : t_reset
	task automatic t_pins();
		i_power_enable_output <= 1'b1;
		i_power_enable_demand <= 1'b1;
		i_logic_enable_pin <= 1'b1;
		rd(ADDR_PIN_CHECK, 16'h0012);
		i_power_enable_output <= 1'b0;
		i_logic_enable_pin <= 1'b0;
		i_battery_enable_pin <= 1'b1;
		rd(ADDR_PIN_CHECK, 16'h0001);
	endtask : t_pins
	task automatic t_rail();
		i_mcu_rail_ok <= 1'b1;
		i_remote_ldo_in_regulation <= 2'h1;
		i_boost_drive_match <= 1'b1;
		i_catch_diode_present <= 1'b0;
		rd(ADDR_RAIL, 16'h4420);
		wr(ADDR_ENABLE, 16'h0044);
		check(16'(o_remote_ldo_enable), 16'h0001);
		rd(ADDR_RAIL, 16'h4620);
	endtask : t_rail
	task automatic t_gates();
		wr(ADDR_ENABLE, 16'hff44);
		i_gate_source_high <= 4'h5;
		i_bridge_supply_low <= 1'b1;
		i_watchdog_state_code <= 3'h3;
		rd(ADDR_GATE_WD, 16'hd003);
		wr(ADDR_ENABLE, 16'hf040);
		check(16'({o_gate_enable, o_remote_ldo_enable}), 16'h003d);
		wr(ADDR_ENABLE, 16'h0);
		check(16'({o_gate_enable, o_remote_ldo_enable}), 16'h0);
		i_bridge_supply_low <= 1'b0;
		i_watchdog_state_code <= 3'h5;
		rd(ADDR_GATE_WD, 16'h002d);
	endtask : t_gates
	task automatic t_count();
		i_pulse_watchdog_error_count <= 8'hc8;
		rd(ADDR_PWWD_COUNT, 16'ha000);
		i_pwwd_max_alt <= 1'b1;
		wr(ADDR_PWWD_COUNT, 16'hffff);
		rd(ADDR_PWWD_COUNT, 16'hc800);
	endtask : t_count
	// Both LDOs are off here, so their events must stay masked.
	task automatic t_latch();
		i_core_rail_event <= 7'h7f;
		i_remote_rail_event <= 6'h3f;
		repeat (10) @(posedge i_clk);
		i_core_rail_event <= 7'h0;
		i_remote_rail_event <= 6'h0;
		rd(ADDR_CORE_LATCH, 16'h0f70);
		check(16'(o_fault_n), 16'h0);
		rd(ADDR_REMOTE_LATCH, 16'hc000);
		wr(ADDR_CORE_LATCH, 16'h0800);
		rd(ADDR_CORE_LATCH, 16'h0770);
		wr(ADDR_CORE_LATCH, 16'hffff);
		wr(ADDR_REMOTE_LATCH, 16'hffff);
		rd(ADDR_REMOTE_LATCH, 16'h0);
		check(16'(o_fault_n), 16'h1);
	endtask : t_latch
	task automatic t_wd();
		int n0;
		n0 = n_cmd;
		for (int c = 0; c < 4; c++) begin
			key(WD_KEY1, 8'h0);
			key(WD_KEY2, 8'h0);
			key(WD_CMD_FLASH + 8'(c), 8'h0);
			check(16'(last_cmd), 16'(c));
		end
		key(WD_KEY1, 8'h0);
		key(8'h55, 8'h0);
		key(WD_KEY2, 8'h0);
		key(WD_CMD_FLASH, 8'h0);
		check(16'(n_cmd - n0), 16'h4);
	endtask : t_wd
	task automatic t_rst();
		i_aux_rail_ok <= 1'b1;
		// A reserved code must leave the last legal state on show.
		i_watchdog_state_code <= 3'h7;
		key(8'h0, RST_KEY1);
		key(8'h0, RST_KEY2);
		key(8'h0, 8'ha6);
		check(16'(o_reset_input_select), 16'h1);
		key(8'h0, RST_KEY1);
		key(8'h0, 8'h11);
		key(8'h0, RST_KEY2);
		key(8'h0, RST_ADD_WDF);
		check(16'(o_reset_input_select), 16'h1);
		key(8'h0, RST_KEY1);
		key(8'h0, RST_KEY2);
		key(8'h0, RST_ADD_BOTH);
		rd(ADDR_GATE_WD, 16'h062d);
		check(16'(o_reset_demand), 16'h1);
		i_watchdog_fault <= 1'b1;
		repeat (10) @(posedge i_clk);
		check(16'(o_reset_demand), 16'h0);
		i_watchdog_fault <= 1'b0;
		repeat (60) @(posedge i_clk);
		check(16'(o_reset_demand), 16'h1);
		rd(ADDR_PIN_CHECK, 16'h0001);
		rst_pin_ok <= 1'b1;
		rd(ADDR_PIN_CHECK, 16'h0009);
		i_rstn <= 1'b0;
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk);
		check(16'(o_reset_input_select), 16'h0);
	endtask : t_rst
	task automatic t_dither();
		wr(ADDR_CONFIG, 16'hffff);
		check(16'(o_dither_disable), 16'h1);
		rd(ADDR_CONFIG, 16'h8000);
	endtask : t_dither
	// Main sequence: reset for 20 cycles, then every scenario in turn.
	initial begin
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk);
		t_reset();
		t_pins();
		t_rail();
		t_gates();
		t_count();
		t_latch();
		t_wd();
		t_rst();
		t_dither();
		stop_test();
	end
endmodule : supervisor_status_control_regs_tb
